//--- hdl/pae_cor_status.sv
`timescale 1ns/1ps
module pae_cor_status
  import pae_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   sw_rst_in,
  input  wire logic   por_b_in,
  input  wire logic   ce_in,
  pae_status_if.holder st
);

  logic [DATA_W-1:0] stat;
  wire  [DATA_W-1:0] next_stat;

  assign st.status = stat;

  genvar g;
  generate
    for (g = 0; g < DATA_W; g++)
    begin : g_bit
      if (COR_BITS[g])
      begin : g_live
        // event in the clearing cycle survives
        assign next_stat[g] = st.set_evt[g]
                            | (stat[g] & ~st.clr_bits[g]);
      end
      else
      begin : g_rsvd
        assign next_stat[g] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_in)
  begin
    if (sw_rst_in)
      stat <= COR_RESET;
    else if (ce_in)
      stat <= next_stat;
  end

  cor_w1c_clear_a: assert property (
    @(posedge clk_in) disable iff (sw_rst_in)
    ce_in |=> ((stat & $past(st.clr_bits) & ~$past(st.set_evt)) == '0))
    else $error("written one did not clear status bit");

  cor_keep_zero_a: assert property (
    @(posedge clk_in) disable iff (sw_rst_in)
    ce_in |=> ((stat ^ $past(stat)) & ~$past(st.clr_bits)
               & ~$past(st.set_evt)) == '0)
    else $error("status bit changed without clear or event");

  cor_reset_zero_a: assert property (
    @(posedge clk_in) disable iff (!por_b_in)
    sw_rst_in |=> (stat == COR_RESET))
    else $error("correctable status not zero after reset");

endmodule : pae_cor_status

//--- hdl/pae_err_regs.sv
`timescale 1ns/1ps
module pae_err_regs
  import pae_pkg::*;
(
  input  wire logic                      REF_CLK_IN,
  input  wire logic                      RST_B_IN,
  input  wire logic                      CE_IN,
  input  wire logic                      LINK_RST_B_IN,
  input  wire logic                      GLOBAL_RESET_INPUT_B_IN,
  input  wire logic                      CFG_WR_IN,
  input  wire logic                      CFG_RD_IN,
  input  wire logic [pae_pkg::ADDR_W-1:0] CFG_ADDR_IN,
  input  wire logic [pae_pkg::DATA_W-1:0] CFG_WDATA_IN,
  input  wire logic [3:0]                CFG_BE_IN,
  input  wire logic [pae_pkg::DATA_W-1:0] UNC_ERR_EVT_IN,
  input  wire logic [pae_pkg::DATA_W-1:0] COR_ERR_EVT_IN,
  output logic      [pae_pkg::DATA_W-1:0] CFG_RDATA_OUT,
  output logic                           CFG_RVALID_OUT,
  output logic      [pae_pkg::DATA_W-1:0] UNC_LOG_OUT,
  output logic                           FATAL_MSG_OUT,
  output logic                           NONFATAL_MSG_OUT,
  output logic      [pae_pkg::DATA_W-1:0] MASK_OUT,
  output logic      [pae_pkg::DATA_W-1:0] SEVERITY_OUT,
  output logic      [pae_pkg::DATA_W-1:0] COR_STATUS_OUT
);
  import pae_pkg::*;

  // global reset pin is asynchronous to the reference clock
  logic                global_reset_input_meta;
  logic                global_reset_input_sync;
  logic [DATA_W-1:0]   uncorrectable_error_mask;
  logic [DATA_W-1:0]   uncorrectable_error_severity;
  logic [DATA_W-1:0]   next_mask;
  logic [DATA_W-1:0]   next_sev;
  logic [DATA_W-1:0]   next_rdata;

  wire                 sw_rst;
  wire  [DATA_W-1:0]   byte_en;
  wire                 hit_mask;
  wire                 hit_sev;
  wire                 hit_cor;
  wire                 wr_mask;
  wire                 wr_sev;
  wire                 wr_cor;
  wire  [DATA_W-1:0]   mask_wr_bits;
  wire  [DATA_W-1:0]   sev_wr_bits;
  wire  [DATA_W-1:0]   mask_rd;
  wire  [DATA_W-1:0]   sev_rd;
  wire  [DATA_W-1:0]   unc_hit;
  wire                 any_fatal;
  wire                 any_nonfatal;

  pae_status_if cor_if ();

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      global_reset_input_meta <= 1'b1;
      global_reset_input_sync <= 1'b1;
    end
    else if (CE_IN)
    begin
      global_reset_input_meta <= GLOBAL_RESET_INPUT_B_IN;
      global_reset_input_sync <= global_reset_input_meta;
    end
  end

  // RST_B_IN, LINK_RST_B_IN or the global reset, which is only synchronized while CE_IN is high, returns every field to its reset value
  assign sw_rst = ~RST_B_IN | ~LINK_RST_B_IN | ~global_reset_input_sync;

  // address decode and byte lanes
  assign byte_en  = {{8{CFG_BE_IN[3]}}, {8{CFG_BE_IN[2]}},
                     {8{CFG_BE_IN[1]}}, {8{CFG_BE_IN[0]}}};
  assign hit_mask = (CFG_ADDR_IN == UNC_MASK_ADDR);
  assign hit_sev  = (CFG_ADDR_IN == UNC_SEV_ADDR);
  assign hit_cor  = (CFG_ADDR_IN == COR_STAT_ADDR);
  assign wr_mask  = CFG_WR_IN & hit_mask;
  assign wr_sev   = CFG_WR_IN & hit_sev;
  assign wr_cor   = CFG_WR_IN & hit_cor;

  // only the assigned field positions accept write data
  assign mask_wr_bits = wr_mask ? (byte_en & UNC_RW_BITS) : '0;
  assign sev_wr_bits  = wr_sev  ? (byte_en & UNC_RW_BITS) : '0;

  assign next_mask = (uncorrectable_error_mask & ~mask_wr_bits)
                   | (CFG_WDATA_IN & mask_wr_bits);
  assign next_sev  = (uncorrectable_error_severity & ~sev_wr_bits)
                   | (CFG_WDATA_IN & sev_wr_bits);

  assign mask_rd = uncorrectable_error_mask & UNC_RW_BITS;
  // fixed ones are not stored, so no write can disturb them
  assign sev_rd  = (uncorrectable_error_severity & UNC_RW_BITS)
                 | SEV_FIXED_ONES;

  // unmapped offsets in this window read as zero
  assign next_rdata = hit_mask ? mask_rd :
                      hit_sev  ? sev_rd :
                      hit_cor  ? cor_if.status :
                      '0;

  // masked errors are dropped before logging or reporting
  assign unc_hit      = UNC_ERR_EVT_IN & ~uncorrectable_error_mask
                      & UNC_RW_BITS;
  assign any_fatal    = |(unc_hit & uncorrectable_error_severity);
  assign any_nonfatal = |(unc_hit & ~uncorrectable_error_severity);

  // correctable status lives in its own holder
  assign cor_if.set_evt  = COR_ERR_EVT_IN & COR_BITS;
  assign cor_if.clr_bits = wr_cor ? (CFG_WDATA_IN & byte_en) : '0;

  pae_cor_status u_cor_status (
    .clk_in    (REF_CLK_IN),
    .sw_rst_in (sw_rst),
    .por_b_in  (RST_B_IN),
    .ce_in     (CE_IN),
    .st        (cor_if.holder)
  );

  always_ff @(posedge REF_CLK_IN)
  begin
    if (sw_rst)
    begin
      uncorrectable_error_mask     <= MASK_RESET;
      uncorrectable_error_severity <= SEV_RESET & UNC_RW_BITS;
    end
    else if (CE_IN)
    begin
      uncorrectable_error_mask     <= next_mask;
      uncorrectable_error_severity <= next_sev;
    end
  end

  // read answer one edge after the request, old value on a same-cycle write
  always_ff @(posedge REF_CLK_IN)
  begin
    if (sw_rst)
    begin
      CFG_RVALID_OUT <= 1'b0;
      CFG_RDATA_OUT  <= '0;
    end
    else if (CE_IN)
    begin
      CFG_RVALID_OUT <= CFG_RD_IN;
      CFG_RDATA_OUT  <= CFG_RD_IN ? next_rdata : '0;
    end
  end

  // report pulses; they hold while the clock enable is low
  always_ff @(posedge REF_CLK_IN)
  begin
    if (sw_rst)
    begin
      UNC_LOG_OUT      <= '0;
      FATAL_MSG_OUT    <= 1'b0;
      NONFATAL_MSG_OUT <= 1'b0;
    end
    else if (CE_IN)
    begin
      UNC_LOG_OUT      <= unc_hit;
      FATAL_MSG_OUT    <= any_fatal;
      NONFATAL_MSG_OUT <= any_nonfatal;
    end
  end

  // mirrors are registered so the outputs come straight from flops
  always_ff @(posedge REF_CLK_IN)
  begin
    if (sw_rst)
    begin
      MASK_OUT       <= MASK_RESET;
      SEVERITY_OUT   <= SEV_RESET & UNC_RW_BITS;
      COR_STATUS_OUT <= COR_RESET;
    end
    else if (CE_IN)
    begin
      MASK_OUT       <= next_mask;
      SEVERITY_OUT   <= next_sev;
      COR_STATUS_OUT <= (cor_if.status & ~cor_if.clr_bits)
                      | cor_if.set_evt;
    end
  end

  sequence mask_full_wr_s;
    CE_IN && wr_mask && (CFG_BE_IN == 4'hf);
  endsequence

  sequence sev_full_wr_s;
    CE_IN && wr_sev && (CFG_BE_IN == 4'hf);
  endsequence

  sequence sev_rd_s;
    CE_IN && CFG_RD_IN && hit_sev && !CFG_WR_IN;
  endsequence

  sequence fatal_evt_s;
    CE_IN && any_fatal;
  endsequence

  mask_write_back_a: assert property (
    @(posedge REF_CLK_IN) disable iff (sw_rst)
    mask_full_wr_s |=> (MASK_OUT == ($past(CFG_WDATA_IN) & UNC_RW_BITS)))
    else $error("mask did not take written field bits");

  mask_rsvd_zero_a: assert property (
    @(posedge REF_CLK_IN) disable iff (sw_rst)
    CFG_RVALID_OUT && $past(hit_mask)
      |-> ((CFG_RDATA_OUT & ~UNC_RW_BITS) == '0))
    else $error("reserved mask bit read nonzero");

  mask_reset_zero_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    !LINK_RST_B_IN |=> (uncorrectable_error_mask == '0))
    else $error("mask not cleared by link reset");

  // bit 21 of the reset word is reserved and reads zero; bit 22 reads one
  sev_reset_val_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    !LINK_RST_B_IN ##1 (LINK_RST_B_IN && !CFG_WR_IN) ##1 sev_rd_s
      |=> CFG_RVALID_OUT && (CFG_RDATA_OUT ==
          ((SEV_RESET & UNC_RW_BITS) | SEV_FIXED_ONES)))
    else $error("severity read after reset is wrong");

  sev_write_back_a: assert property (
    @(posedge REF_CLK_IN) disable iff (sw_rst)
    sev_full_wr_s ##1 !wr_sev ##1 sev_rd_s |=> CFG_RVALID_OUT &&
      (CFG_RDATA_OUT == (($past(CFG_WDATA_IN, 3) & UNC_RW_BITS)
                         | SEV_FIXED_ONES)))
    else $error("severity read back mismatch");

  sev_fixed_one_a: assert property (
    @(posedge REF_CLK_IN) disable iff (sw_rst)
    sev_rd_s |=> ((CFG_RDATA_OUT & ~UNC_RW_BITS) == SEV_FIXED_ONES))
    else $error("reserved severity bits read wrong");

  fatal_report_a: assert property (
    @(posedge REF_CLK_IN) disable iff (sw_rst)
    fatal_evt_s |=> FATAL_MSG_OUT)
    else $error("fatal error not reported as fatal");

  nonfatal_only_a: assert property (
    @(posedge REF_CLK_IN) disable iff (sw_rst)
    CE_IN && !any_fatal && (unc_hit != '0)
      |=> NONFATAL_MSG_OUT && !FATAL_MSG_OUT)
    else $error("non-fatal error reported wrongly");

  masked_no_log_a: assert property (
    @(posedge REF_CLK_IN) disable iff (sw_rst)
    CE_IN |=> ((UNC_LOG_OUT & $past(uncorrectable_error_mask)) == '0))
    else $error("masked error was logged");

  unmasked_log_a: assert property (
    @(posedge REF_CLK_IN) disable iff (sw_rst)
    CE_IN |=> (UNC_LOG_OUT == ($past(UNC_ERR_EVT_IN)
               & ~$past(uncorrectable_error_mask) & UNC_RW_BITS)))
    else $error("unmasked error log mismatch");

  rsvd_write_ign_a: assert property (
    @(posedge REF_CLK_IN) disable iff (sw_rst)
    CE_IN && (wr_mask || wr_sev) |=>
      ((uncorrectable_error_mask | uncorrectable_error_severity)
       & ~UNC_RW_BITS) == '0)
    else $error("reserved position took write data");

  global_reset_input_clears_a: assert property (
    @(posedge REF_CLK_IN) disable iff (!RST_B_IN)
    !global_reset_input_sync |=> (MASK_OUT == MASK_RESET) && !FATAL_MSG_OUT)
    else $error("global reset did not restore fields");

endmodule : pae_err_regs

//--- hdl/pae_pkg.sv
package pae_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // extended configuration offsets (byte addresses)
  localparam logic [ADDR_W-1:0] UNC_MASK_ADDR = 12'h108;
  localparam logic [ADDR_W-1:0] UNC_SEV_ADDR  = 12'h10c;
  localparam logic [ADDR_W-1:0] COR_STAT_ADDR = 12'h110;

  // uncorrectable error field positions, shared by mask and severity
  localparam int UNSUP_REQ_POS    = 20;
  localparam int E2E_CRC_POS      = 19;
  localparam int MALFORMED_POS    = 18;
  localparam int RX_OVERRUN_POS   = 17;
  localparam int UNEXP_CPL_POS    = 16;
  localparam int CPL_ABORT_POS    = 15;
  localparam int CPL_TIMEOUT_POS  = 14;
  localparam int FLOW_CREDIT_POS  = 13;
  localparam int POISONED_POS     = 12;
  localparam int LINK_PROT_POS    = 4;

  // fixed-one reserved severity positions
  localparam int SEV_ONE_HI_POS   = 22;
  localparam int SEV_ONE_LO_POS   = 5;

  // correctable status field positions
  localparam int ADV_NONFATAL_POS = 13;
  localparam int REPLAY_TMO_POS   = 12;
  localparam int REPLAY_ROLL_POS  = 8;
  localparam int BAD_DLLP_POS     = 7;
  localparam int BAD_TLP_POS      = 6;
  localparam int RX_ERR_POS       = 0;

  localparam logic [DATA_W-1:0] ONE = 32'h0000_0001;

  localparam logic [DATA_W-1:0] UNC_RW_BITS =
    (ONE << UNSUP_REQ_POS)   | (ONE << E2E_CRC_POS)     |
    (ONE << MALFORMED_POS)   | (ONE << RX_OVERRUN_POS)  |
    (ONE << UNEXP_CPL_POS)   | (ONE << CPL_ABORT_POS)   |
    (ONE << CPL_TIMEOUT_POS) | (ONE << FLOW_CREDIT_POS) |
    (ONE << POISONED_POS)    | (ONE << LINK_PROT_POS);

  localparam logic [DATA_W-1:0] SEV_FIXED_ONES =
    (ONE << SEV_ONE_HI_POS) | (ONE << SEV_ONE_LO_POS);

  localparam logic [DATA_W-1:0] COR_BITS =
    (ONE << ADV_NONFATAL_POS) | (ONE << REPLAY_TMO_POS) |
    (ONE << REPLAY_ROLL_POS)  | (ONE << BAD_DLLP_POS)   |
    (ONE << BAD_TLP_POS)      | (ONE << RX_ERR_POS);

  localparam logic [DATA_W-1:0] MASK_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] SEV_RESET  = 32'h0026_2030;
  localparam logic [DATA_W-1:0] COR_RESET  = 32'h0000_0000;

endpackage : pae_pkg

//--- hdl/pae_status_if.sv
`timescale 1ns/1ps
interface pae_status_if;
  import pae_pkg::*;

  logic [DATA_W-1:0] set_evt;
  logic [DATA_W-1:0] clr_bits;
  logic [DATA_W-1:0] status;

  modport owner  (output set_evt, output clr_bits, input status);
  modport holder (input set_evt, input clr_bits, output status);
endinterface : pae_status_if

//--- verification/pae_cfg_host.sv
`timescale 1ns/1ps
module pae_cfg_host
(
  input  wire logic                      clk_in,
  input  wire logic [pae_pkg::DATA_W-1:0] rdata_in,
  input  wire logic                      rvalid_in,
  output logic                           wr_out,
  output logic                           rd_out,
  output logic      [pae_pkg::ADDR_W-1:0] addr_out,
  output logic      [pae_pkg::DATA_W-1:0] wdata_out,
  output logic      [3:0]                be_out
);
  import pae_pkg::*;

  initial
  begin
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    addr_out  = 12'h000;
    wdata_out = 32'h0000_0000;
    be_out    = 4'h0;
  end

  // released lines flip so stale data never looks live
  task automatic cfg_wr(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d,
                        input logic [3:0]        be);
    @(posedge clk_in);
    wr_out    <= 1'b1;
    addr_out  <= a;
    wdata_out <= d;
    be_out    <= be;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
    be_out    <= ~be;
  endtask : cfg_wr

  // answer is due exactly one edge after the taking edge
  task automatic cfg_rd(input  logic [ADDR_W-1:0] a,
                        output logic [DATA_W-1:0] d,
                        output logic              v);
    @(posedge clk_in);
    rd_out   <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    v = rvalid_in;
    d = rdata_in;
  endtask : cfg_rd
endmodule : pae_cfg_host

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  import pae_pkg::*;

  logic              clk;
  logic              rst_b;
  logic              ce;
  logic              link_b;
  logic              glob_b;
  logic              wr;
  logic              rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [3:0]        be;
  logic [DATA_W-1:0] unc_evt;
  logic [DATA_W-1:0] cor_evt;
  logic [DATA_W-1:0] rdata;
  logic              rvalid;
  logic [DATA_W-1:0] unc_log;
  logic              fatal;
  logic              nonfatal;
  logic [DATA_W-1:0] mask_o;
  logic [DATA_W-1:0] sev_o;
  logic [DATA_W-1:0] cor_o;

  // reserved bit 21 of the reset word reads zero, bit 22 reads one
  localparam logic [DATA_W-1:0] SEV_RD_RESET =
    (SEV_RESET & UNC_RW_BITS) | SEV_FIXED_ONES;
  int                failures;
  int                checks;
  int                cyc;

  pae_err_regs i_dut (
    .REF_CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce),
    .LINK_RST_B_IN(link_b), .GLOBAL_RESET_INPUT_B_IN(glob_b),
    .CFG_WR_IN(wr), .CFG_RD_IN(rd), .CFG_ADDR_IN(addr),
    .CFG_WDATA_IN(wdata), .CFG_BE_IN(be), .UNC_ERR_EVT_IN(unc_evt),
    .COR_ERR_EVT_IN(cor_evt), .CFG_RDATA_OUT(rdata),
    .CFG_RVALID_OUT(rvalid), .UNC_LOG_OUT(unc_log), .FATAL_MSG_OUT(fatal),
    .NONFATAL_MSG_OUT(nonfatal), .MASK_OUT(mask_o), .SEVERITY_OUT(sev_o),
    .COR_STATUS_OUT(cor_o));

  pae_cfg_host i_host (
    .clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid), .wr_out(wr),
    .rd_out(rd), .addr_out(addr), .wdata_out(wdata), .be_out(be));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // ceiling well above the roughly 120 cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        v;
    i_host.cfg_rd(a, d, v);
    chk({31'h0, v}, 32'h1);
    chk(d, exp);
  endtask : rd_chk

  task automatic evt(input logic [31:0] e, input logic [31:0] log_exp,
                     input logic f_exp, input logic nf_exp);
    @(posedge clk);
    unc_evt <= e;
    @(posedge clk);
    unc_evt <= 32'h0;
    @(posedge clk);
    chk(unc_log, log_exp);
    chk({31'h0, fatal}, {31'h0, f_exp});
    chk({31'h0, nonfatal}, {31'h0, nf_exp});
  endtask : evt

  task automatic t_reset();
    rd_chk(UNC_MASK_ADDR, MASK_RESET);
    rd_chk(UNC_SEV_ADDR, SEV_RD_RESET);
    rd_chk(COR_STAT_ADDR, COR_RESET);
    rd_chk(12'h114, 32'h0);
    chk(mask_o, MASK_RESET);
    chk(sev_o, SEV_RESET & UNC_RW_BITS);
    chk(cor_o, COR_RESET);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_mask();
    i_host.cfg_wr(UNC_MASK_ADDR, 32'hffff_ffff, 4'hf);
    rd_chk(UNC_MASK_ADDR, UNC_RW_BITS);
    chk(mask_o, UNC_RW_BITS);
    i_host.cfg_wr(UNC_MASK_ADDR, 32'h0, 4'h4);
    rd_chk(UNC_MASK_ADDR, UNC_RW_BITS & 32'hff00_ffff);
    i_host.cfg_wr(UNC_MASK_ADDR, 32'h0, 4'hf);
    rd_chk(UNC_MASK_ADDR, 32'h0);
    $display("t_mask done");
  endtask : t_mask

  task automatic t_sev();
    i_host.cfg_wr(UNC_SEV_ADDR, 32'hffff_ffff, 4'hf);
    rd_chk(UNC_SEV_ADDR, UNC_RW_BITS | SEV_FIXED_ONES);
    i_host.cfg_wr(UNC_SEV_ADDR, 32'h0, 4'hf);
    rd_chk(UNC_SEV_ADDR, SEV_FIXED_ONES);
    i_host.cfg_wr(UNC_SEV_ADDR, 32'h1 << MALFORMED_POS, 4'hf);
    $display("t_sev done");
  endtask : t_sev

  task automatic t_err();
    evt(32'h1 << UNSUP_REQ_POS, 32'h1 << UNSUP_REQ_POS, 1'b0, 1'b1);
    evt(32'h0004_0001, 32'h1 << MALFORMED_POS, 1'b1, 1'b0);
    i_host.cfg_wr(UNC_MASK_ADDR, 32'h1 << UNSUP_REQ_POS, 4'hf);
    evt(32'h1 << UNSUP_REQ_POS, 32'h0, 1'b0, 1'b0);
    $display("t_err done");
  endtask : t_err

  task automatic t_cor();
    @(posedge clk);
    cor_evt <= COR_BITS | 32'h0000_0002;
    @(posedge clk);
    cor_evt <= 32'h0;
    rd_chk(COR_STAT_ADDR, COR_BITS);
    chk(cor_o, COR_BITS);
    i_host.cfg_wr(COR_STAT_ADDR, 32'h0, 4'hf);
    rd_chk(COR_STAT_ADDR, COR_BITS);
    i_host.cfg_wr(COR_STAT_ADDR, 32'h1 << RX_ERR_POS, 4'hf);
    rd_chk(COR_STAT_ADDR, COR_BITS & ~(32'h1 << RX_ERR_POS));
    chk(cor_o, COR_BITS & ~(32'h1 << RX_ERR_POS));
    $display("t_cor done");
  endtask : t_cor

  task automatic t_rst();
    i_host.cfg_wr(UNC_MASK_ADDR, 32'hffff_ffff, 4'hf);
    @(posedge clk);
    link_b <= 1'b0;
    @(posedge clk);
    link_b <= 1'b1;
    rd_chk(UNC_SEV_ADDR, SEV_RD_RESET);
    rd_chk(UNC_MASK_ADDR, MASK_RESET);
    chk(sev_o, SEV_RESET & UNC_RW_BITS);
    i_host.cfg_wr(UNC_MASK_ADDR, 32'hffff_ffff, 4'hf);
    @(posedge clk);
    glob_b <= 1'b0;
    repeat (5) @(posedge clk);
    glob_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(UNC_MASK_ADDR, MASK_RESET);
    rd_chk(COR_STAT_ADDR, COR_RESET);
    $display("t_rst done");
  endtask : t_rst

  task automatic t_ce();
    @(posedge clk);
    ce <= 1'b0;
    // a write while the enable is low must not be taken
    i_host.cfg_wr(UNC_MASK_ADDR, 32'hffff_ffff, 4'hf);
    @(posedge clk);
    ce <= 1'b1;
    chk(mask_o, MASK_RESET);
    rd_chk(UNC_MASK_ADDR, MASK_RESET);
    $display("t_ce done");
  endtask : t_ce

  initial
  begin
    failures = 0;
    checks   = 0;
    cyc      = 0;
    rst_b    = 1'b0;
    ce       = 1'b1;
    link_b   = 1'b1;
    glob_b   = 1'b1;
    unc_evt  = 32'h0;
    cor_evt  = 32'h0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_mask();
    t_sev();
    t_err();
    t_cor();
    t_rst();
    t_ce();
    final_report();
  end
endmodule : tb
